/* pxb_defs.vh */
`ifndef PXB_DEFS_VH
`define PXB_DEFS_VH
// register addresses
`define PXB_ADDR_P0_LATCH  8'h80
`define PXB_ADDR_P1_LATCH  8'h90
`define PXB_ADDR_P0_MODE   8'ha4
`define PXB_ADDR_P1_MODE   8'ha5
`define PXB_ADDR_P1_KIND   8'had
`define PXB_ADDR_SEL_A     8'he1
`define PXB_ADDR_SEL_B     8'he2
`define PXB_ADDR_SEL_C     8'he3
`define PXB_ADDR_SEL_D     8'he4
// page holding the mode and routing registers
`define PXB_CFG_PAGE       8'h0f
// reset values
`define PXB_RST_LATCH      8'hff
`define PXB_RST_MODE       8'h00
`define PXB_RST_KIND       8'hff
`define PXB_RST_SEL        8'h00
// writable masks
`define PXB_MASK_SEL_C     8'hdc
`define PXB_MASK_SEL_D     8'h8f
// routing_select_a fields
`define PXB_A_CMP          7
`define PXB_A_ECI          6
`define PXB_A_CNT_HI       5
`define PXB_A_CNT_LO       3
`define PXB_A_SER          2
`define PXB_A_SPI          1
`define PXB_A_SMB          0
// routing_select_b fields
`define PXB_B_CLK          7
`define PXB_B_T2X          6
`define PXB_B_T2           5
`define PXB_B_IRQB         4
`define PXB_B_T1           3
`define PXB_B_IRQA         2
`define PXB_B_T0           1
`define PXB_B_CMPB         0
// routing_select_c fields
`define PXB_C_PUOFF        7
`define PXB_C_XEN          6
`define PXB_C_T4X          4
`define PXB_C_T4           3
`define PXB_C_SERB         2
// routing_select_d fields
`define PXB_D_CANPP        7
`define PXB_D_CMPC         3
`define PXB_D_CNV          2
`define PXB_D_T3X          1
`define PXB_D_T3           0
`endif

/* pxb_crossbar.v */
// Contract
// R1 - comparator a and ext count routed when set
// R2 - capture field routes modules zero to n-1, at most modules zero to five
// R3 - serial a on port0 pins 0 and 1
// R4 - spi three pins, four in four-wire
// R5 - smbus data and clock on two pins
// R6 - inverted clock routed when bit set
// R7 - second register bits route timer/irq inputs
// R8 - pullup disable bit kills all pullups
// R9 - crossbar off forces pins to input
// R10 - unused bit5 reads zero, ignores writes
// R11 - timer4 inputs and serial b routing
// R12 - can tx drive mode bit seven
// R13 - comparator c, convert start, timer3 routing
// R14 - latch drives pin, open-drain releases high
// R15 - port reads return pin level
// R16 - data regs any page, modes page f
// R17 - drive mode bit selects push-pull
// R18 - smbus and mode0 receive forced open-drain
// R19 - analog input reads zero, no pullup
// R20 - analog pins skipped, drive follows latch
// R21 - routing registers reset to zero
// R22 - no pullup on pin driven low
// R23 - read-modify-write reads return latch
// R24 - signals packed onto pins by priority
// R25 - routing changes follow register write
`include "pxb_defs.vh"
`timescale 1ns/10ps
`default_nettype none
module pxb_crossbar (
  input  wire        sys_clk,            // system clock
  input  wire        rstn,               // async reset, low
  input  wire [7:0]  sfr_addr,           // register address
  input  wire [7:0]  sfr_page,           // current register page
  input  wire        sfr_wr,             // byte write strobe
  input  wire        sfr_rd,             // byte read strobe
  input  wire        rmw_read,           // rmw read phase
  input  wire [7:0]  sfr_wdata,          // write data
  output reg  [7:0]  sfr_rdata,          // read data, next cycle
  input  wire        bit_wr,             // bit write strobe
  input  wire        bit_rd,             // bit read strobe
  input  wire [7:0]  bit_addr,           // bit address
  input  wire        bit_wdata,          // bit write value
  output reg         bit_rdata,          // bit read value
  input  wire        spi_four_wire,      // spi in four-wire mode
  input  wire        uart0_mode0,        // serial a in mode 0
  input  wire        uart1_mode0,        // serial b in mode 0
  input  wire        inverted_sys_clock, // clock out source
  input  wire [31:0] periph_out,         // peripheral out values
  input  wire [31:0] periph_oe,          // peripheral drives
  output reg  [31:0] periph_in,          // pin level to peripheral
  input  wire [15:0] pin_in,             // pin levels p1:p0
  output reg  [15:0] pin_out,            // pin drive value
  output reg  [15:0] pin_oe,             // pin drive enable
  output reg  [15:0] pullup_en,          // weak pullup on
  output wire [7:0]  slow_adc_analog_in, // p1 pins in analog
  output wire        can_tx_drive_mode   // 1 push-pull
);

  localparam NPIN = 16;
  localparam NSIG = 32;
  localparam SIG_CLK = 30;

  reg  [7:0] p0_latch_ff;
  reg  [7:0] p1_latch_ff;
  reg  [7:0] p0_mode_ff;
  reg  [7:0] p1_mode_ff;
  reg  [7:0] p1_kind_ff;
  reg  [7:0] sel_a_ff;
  reg  [7:0] sel_b_ff;
  reg  [7:0] sel_c_ff;
  reg  [7:0] sel_d_ff;
  reg  [7:0] nxt_p0_latch;
  reg  [7:0] nxt_p1_latch;
  reg  [7:0] nxt_rdata;
  reg        nxt_bit_rdata;

  wire       cfg_pg;
  wire       wr_cfg;
  wire [2:0] cap_cnt;
  wire       xen;
  wire       pu_off;
  wire [15:0] avail;
  wire [15:0] latch_all;
  wire [15:0] mode_all;
  wire [15:0] digital;
  wire [7:0] p0_read;
  wire [7:0] p1_read;

  reg  [31:0] req;
  reg  [31:0] force_od;
  reg  [31:0] sig_drv;
  reg  [5:0]  sig_rank [0:NSIG-1];
  reg  [5:0]  pin_rank [0:NPIN-1];
  reg  [4:0]  pin_sel  [0:NPIN-1];
  reg  [15:0] pin_used;
  reg  [5:0]  cnt;
  reg  [5:0]  pcnt;
  reg         val;
  reg         od;
  integer     k;
  integer     p;
  integer     m;
  integer     q;

  // R16 page decode for mode registers
  assign cfg_pg = (sfr_page == `PXB_CFG_PAGE);
  assign wr_cfg = sfr_wr & cfg_pg;

  assign cap_cnt = sel_a_ff[`PXB_A_CNT_HI:`PXB_A_CNT_LO];
  assign xen     = sel_c_ff[`PXB_C_XEN];
  assign pu_off  = sel_c_ff[`PXB_C_PUOFF];
  assign can_tx_drive_mode = sel_d_ff[`PXB_D_CANPP];
  assign slow_adc_analog_in = ~p1_kind_ff;

  assign latch_all = {p1_latch_ff, p0_latch_ff};
  assign mode_all  = {p1_mode_ff, p0_mode_ff};
  assign digital   = {p1_kind_ff, 8'hff};
  // R20 analog port1 pins skipped
  assign avail = digital & {NPIN{xen}};

  // R15 pin level reads
  // R19 analog pins read zero
  // R23 rmw read returns latch
  assign p0_read = rmw_read ? p0_latch_ff : pin_in[7:0];
  assign p1_read = rmw_read ? p1_latch_ff
                            : (pin_in[15:8] & p1_kind_ff);

  // latch next values, byte then bit
  always @*
  begin
    nxt_p0_latch = p0_latch_ff;
    nxt_p1_latch = p1_latch_ff;
    // R16 data regs on every page
    if (sfr_wr && sfr_addr == `PXB_ADDR_P0_LATCH)
      nxt_p0_latch = sfr_wdata;
    if (sfr_wr && sfr_addr == `PXB_ADDR_P1_LATCH)
      nxt_p1_latch = sfr_wdata;
    if (bit_wr && bit_addr[7:3] == 5'h10)
      nxt_p0_latch[bit_addr[2:0]] = bit_wdata;
    if (bit_wr && bit_addr[7:3] == 5'h12)
      nxt_p1_latch[bit_addr[2:0]] = bit_wdata;
  end

  // read data mux, unmapped reads zero
  always @*
  begin
    nxt_rdata = 8'h00;
    case (sfr_addr)
      `PXB_ADDR_P0_LATCH: nxt_rdata = p0_read;
      `PXB_ADDR_P1_LATCH: nxt_rdata = p1_read;
      default:
      begin
        if (cfg_pg)
        begin
          case (sfr_addr)
            `PXB_ADDR_P0_MODE: nxt_rdata = p0_mode_ff;
            `PXB_ADDR_P1_MODE: nxt_rdata = p1_mode_ff;
            `PXB_ADDR_P1_KIND: nxt_rdata = p1_kind_ff;
            `PXB_ADDR_SEL_A:   nxt_rdata = sel_a_ff;
            `PXB_ADDR_SEL_B:   nxt_rdata = sel_b_ff;
            // R10 unused bits read zero
            `PXB_ADDR_SEL_C:   nxt_rdata = sel_c_ff;
            `PXB_ADDR_SEL_D:   nxt_rdata = sel_d_ff;
            default:           nxt_rdata = 8'h00;
          endcase
        end
      end
    endcase
  end

  // bit read mux
  always @*
  begin
    nxt_bit_rdata = 1'b0;
    if (bit_addr[7:3] == 5'h10)
      nxt_bit_rdata = p0_read[bit_addr[2:0]];
    else if (bit_addr[7:3] == 5'h12)
      nxt_bit_rdata = p1_read[bit_addr[2:0]];
  end

  // register file
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      // R14 latches reset high
      p0_latch_ff <= `PXB_RST_LATCH;
      p1_latch_ff <= `PXB_RST_LATCH;
      // R17 all pins open-drain
      p0_mode_ff  <= `PXB_RST_MODE;
      p1_mode_ff  <= `PXB_RST_MODE;
      p1_kind_ff  <= `PXB_RST_KIND;
      // R21 routing cleared at reset
      sel_a_ff    <= `PXB_RST_SEL;
      sel_b_ff    <= `PXB_RST_SEL;
      sel_c_ff    <= `PXB_RST_SEL;
      sel_d_ff    <= `PXB_RST_SEL;
      sfr_rdata   <= 8'h00;
      bit_rdata   <= 1'b0;
    end
    else
    begin
      p0_latch_ff <= nxt_p0_latch;
      p1_latch_ff <= nxt_p1_latch;
      if (wr_cfg && sfr_addr == `PXB_ADDR_P0_MODE)
        p0_mode_ff <= sfr_wdata;
      if (wr_cfg && sfr_addr == `PXB_ADDR_P1_MODE)
        p1_mode_ff <= sfr_wdata;
      if (wr_cfg && sfr_addr == `PXB_ADDR_P1_KIND)
        p1_kind_ff <= sfr_wdata;
      // R25 routing applies after write
      if (wr_cfg && sfr_addr == `PXB_ADDR_SEL_A)
        sel_a_ff <= sfr_wdata;
      if (wr_cfg && sfr_addr == `PXB_ADDR_SEL_B)
        sel_b_ff <= sfr_wdata;
      // R10 masked writes
      if (wr_cfg && sfr_addr == `PXB_ADDR_SEL_C)
        sel_c_ff <= sfr_wdata & `PXB_MASK_SEL_C;
      // R12 drive mode stored
      if (wr_cfg && sfr_addr == `PXB_ADDR_SEL_D)
        sel_d_ff <= sfr_wdata & `PXB_MASK_SEL_D;
      if (sfr_rd)
        sfr_rdata <= nxt_rdata;
      if (bit_rd)
        bit_rdata <= nxt_bit_rdata;
    end
  end

  // routing requests in priority order
  always @*
  begin
    req = 32'h00000000;
    // R3 serial a first, lands on p0.0/p0.1
    req[0] = sel_a_ff[`PXB_A_SER];
    req[1] = sel_a_ff[`PXB_A_SER];
    // R4 spi clock, miso, mosi, select
    req[2] = sel_a_ff[`PXB_A_SPI];
    req[3] = sel_a_ff[`PXB_A_SPI];
    req[4] = sel_a_ff[`PXB_A_SPI];
    req[5] = sel_a_ff[`PXB_A_SPI] & spi_four_wire;
    // R5 smbus data and clock
    req[6] = sel_a_ff[`PXB_A_SMB];
    req[7] = sel_a_ff[`PXB_A_SMB];
    // R11 serial b pair
    req[8] = sel_c_ff[`PXB_C_SERB];
    req[9] = sel_c_ff[`PXB_C_SERB];
    // R2 capture modules below count
    for (m = 0; m < 6; m = m + 1)
      req[10+m] = (cap_cnt > m[2:0]);
    // R1 ext count and comparator a
    req[16] = sel_a_ff[`PXB_A_ECI];
    req[17] = sel_a_ff[`PXB_A_CMP];
    // R7 comparator b
    req[18] = sel_b_ff[`PXB_B_CMPB];
    // R13 comparator c
    req[19] = sel_d_ff[`PXB_D_CMPC];
    // R7 timer and irq inputs
    req[20] = sel_b_ff[`PXB_B_T0];
    req[21] = sel_b_ff[`PXB_B_IRQA];
    req[22] = sel_b_ff[`PXB_B_T1];
    req[23] = sel_b_ff[`PXB_B_IRQB];
    req[24] = sel_b_ff[`PXB_B_T2];
    req[25] = sel_b_ff[`PXB_B_T2X];
    // R13 timer3 inputs
    req[26] = sel_d_ff[`PXB_D_T3];
    req[27] = sel_d_ff[`PXB_D_T3X];
    // R11 timer4 inputs
    req[28] = sel_c_ff[`PXB_C_T4];
    req[29] = sel_c_ff[`PXB_C_T4X];
    // R6 inverted clock out
    req[SIG_CLK] = sel_b_ff[`PXB_B_CLK];
    // R13 convert start input
    req[31] = sel_d_ff[`PXB_D_CNV];
  end

  // forced open-drain and drive values
  always @*
  begin
    // R18 smbus and mode0 receive open-drain
    force_od = 32'h000000c0;
    force_od[1] = uart0_mode0;
    force_od[9] = uart1_mode0;
    sig_drv = periph_out;
    sig_drv[SIG_CLK] = inverted_sys_clock;
  end

  // R24 rank signals and pins, match ranks
  always @*
  begin
    cnt = 6'h00;
    for (k = 0; k < NSIG; k = k + 1)
    begin
      sig_rank[k] = cnt;
      if (req[k])
        cnt = cnt + 6'h01;
    end
    pcnt = 6'h00;
    for (p = 0; p < NPIN; p = p + 1)
    begin
      pin_rank[p] = pcnt;
      if (avail[p])
        pcnt = pcnt + 6'h01;
    end
    pin_used = 16'h0000;
    for (p = 0; p < NPIN; p = p + 1)
    begin
      pin_sel[p] = 5'h00;
      for (k = 0; k < NSIG; k = k + 1)
      begin
        if (req[k] && avail[p] && sig_rank[k] == pin_rank[p])
        begin
          pin_used[p] = 1'b1;
          pin_sel[p] = k[4:0];
        end
      end
    end
  end

  // pin drive, pullup and peripheral inputs
  always @*
  begin
    val = 1'b1;
    od  = 1'b1;
    periph_in = 32'hffffffff;
    for (q = 0; q < NPIN; q = q + 1)
    begin
      // R14 latch value when not routed
      val = latch_all[q];
      // R17 drive mode bit
      od  = ~mode_all[q];
      if (pin_used[q])
      begin
        val = periph_oe[pin_sel[q]] ? sig_drv[pin_sel[q]] : 1'b1;
        od  = od | force_od[pin_sel[q]];
        periph_in[pin_sel[q]] = pin_in[q];
      end
      // R14 open-drain high releases pin
      pin_out[q] = val;
      pin_oe[q]  = ~(od & val);
      // R9 crossbar off means input
      if (!xen)
        pin_oe[q] = 1'b0;
      // R8 global pullup disable
      // R19 analog pin pullup off
      // R22 no pullup while driving low
      pullup_en[q] = ~pu_off & digital[q]
                   & ~(pin_oe[q] & ~pin_out[q]);
    end
  end

endmodule
`default_nettype wire

/* pxb_crossbar_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module pxb_crossbar_chk (
  input wire        sys_clk,            // system clock
  input wire        rstn,               // async reset, low
  input wire [7:0]  sfr_addr,           // register address
  input wire [7:0]  sfr_page,           // register page
  input wire [7:0]  sfr_wdata,          // write data
  input wire [7:0]  sfr_rdata,          // read data
  input wire [7:0]  bit_addr,           // bit address
  input wire [7:0]  slow_adc_analog_in, // analog pins
  input wire        sfr_wr,             // byte write
  input wire        sfr_rd,             // byte read
  input wire        rmw_read,           // rmw read phase
  input wire        bit_wr,             // bit write
  input wire        bit_wdata,          // bit value
  input wire        can_tx_drive_mode,  // can tx mode
  input wire [15:0] pin_in,             // pin levels
  input wire [15:0] pin_out,            // pin value
  input wire [15:0] pin_oe,             // pin enable
  input wire [15:0] pullup_en           // pullups
);
  reg  [7:0] lat0_ff;
  reg        xen_ff;
  reg        puoff_ff;
  wire       cfg_c = sfr_wr && sfr_page == 8'h0f && sfr_addr == 8'he3;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // mirror of port0 latch and global enables
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lat0_ff <= 8'hff;
      xen_ff <= 1'b0;
      puoff_ff <= 1'b0;
    end
    else
    begin
      if (sfr_wr && sfr_addr == 8'h80)
        lat0_ff <= sfr_wdata;
      if (bit_wr && bit_addr[7:3] == 5'h10)
        lat0_ff[bit_addr[2:0]] <= bit_wdata;
      if (cfg_c)
      begin
        xen_ff <= sfr_wdata[6];
        puoff_ff <= sfr_wdata[7];
      end
    end
  end
  property p_xoff; !xen_ff |-> pin_oe == 16'h0000; endproperty
  a_xoff: assert property (p_xoff) else $error("pin driven with crossbar off");
  property p_puoff; puoff_ff |-> pullup_en == 16'h0000; endproperty
  a_puoff: assert property (p_puoff) else $error("pullup on while disabled");
  property p_nofight; (pin_oe & ~pin_out & pullup_en) == 16'h0000; endproperty
  a_nofight: assert property (p_nofight) else $error("pullup on low driven pin");
  property p_pinrd; sfr_rd && sfr_addr == 8'h80 && !rmw_read |=> sfr_rdata == $past(pin_in[7:0]); endproperty
  a_pinrd: assert property (p_pinrd) else $error("port0 read not pin level");
  property p_rmw; sfr_rd && sfr_addr == 8'h80 && rmw_read |=> sfr_rdata == $past(lat0_ff); endproperty
  a_rmw: assert property (p_rmw) else $error("rmw read not latch");
  property p_analog;
    sfr_rd && sfr_addr == 8'h90 && !rmw_read |=> sfr_rdata == ($past(pin_in[15:8]) & ~$past(slow_adc_analog_in));
  endproperty
  a_analog: assert property (p_analog) else $error("analog pin read not zero");
  property p_cantx; sfr_wr && sfr_page == 8'h0f && sfr_addr == 8'he4 |=> can_tx_drive_mode == $past(sfr_wdata[7]);
  endproperty
  a_cantx: assert property (p_cantx) else $error("can tx mode not updated");
  property p_unused; sfr_rd && sfr_addr == 8'he3 |=> sfr_rdata[5] == 1'b0 && sfr_rdata[1:0] == 2'b00; endproperty
  a_unused: assert property (p_unused) else $error("unused bits read nonzero");
  property p_page; sfr_rd && sfr_page != 8'h0f && sfr_addr[7:4] == 4'he |=> sfr_rdata == 8'h00; endproperty
  a_page: assert property (p_page) else $error("config read off page");
  c_rmw: cover property (sfr_rd && rmw_read);
  c_xen: cover property (xen_ff && pin_oe != 16'h0000);
  c_page: cover property (sfr_rd && sfr_page != 8'h0f);
endmodule
bind pxb_crossbar pxb_crossbar_chk u_chk (.*);
`default_nettype wire

/* pxb_pins_model.sv */
`timescale 1ns/10ps
`default_nettype none
module pxb_pins_model (
  input  wire        sys_clk,   // system clock
  input  wire [15:0] pin_out,   // device drive value
  input  wire [15:0] pin_oe,    // device drive enable
  input  wire [15:0] pullup_en, // device pullups
  input  wire [15:0] ext_low,   // outside pulls pin low
  output wire [15:0] pin_in     // resolved pin level
);
  reg flt_ff = 1'b0;
  // a pin with nothing on it wanders every cycle
  always @(posedge sys_clk)
    flt_ff <= ~flt_ff;
  // device drive, else outside pull-down, else pullup, else float
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ~ext_low & (pullup_en | {16{flt_ff}}));
endmodule
`default_nettype wire

/* pxb_crossbar_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module pxb_crossbar_tb;
  reg         sys_clk = 1'b0;
  reg         rstn = 1'b0;
  reg  [7:0]  sfr_addr = 8'h00, sfr_page = 8'h0f, sfr_wdata = 8'h00, bit_addr = 8'h00;
  reg         sfr_wr = 1'b0, sfr_rd = 1'b0, rmw_read = 1'b0, bit_wr = 1'b0, bit_wdata = 1'b0;
  reg         spi_four_wire = 1'b0, inverted_sys_clock = 1'b0;
  reg         bit_rd = 1'b0, uart0_mode0 = 1'b0, uart1_mode0 = 1'b0;
  reg  [31:0] periph_out = 32'h0, periph_oe = 32'hffffffff;
  reg  [15:0] ext_low = 16'h0000;
  wire [7:0]  sfr_rdata, slow_adc_analog_in;
  wire [31:0] periph_in;
  wire [15:0] pin_in, pin_out, pin_oe, pullup_en;
  wire        bit_rdata, can_tx_drive_mode;
  integer     mismatches = 0, n_tests = 0, i;
  pxb_crossbar uut (.*);
  pxb_pins_model u_pins (.*);
  // clock and hang guard
  initial
    forever #2 sys_clk = ~sys_clk;
  initial
  begin
    #100000;
    mismatches = mismatches + 1;
    report_and_stop;
  end
  task chk(input [15:0] got, input [15:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge sys_clk) #1;
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(posedge sys_clk) #1;
      sfr_wr = 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      @(posedge sys_clk) #1;
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(posedge sys_clk) #1;
      sfr_rd = 1'b0;
      chk(sfr_rdata, e);
    end
  endtask
  // single bit read, value checked after the taking edge
  task btrd(input [7:0] a, input e);
    begin
      @(posedge sys_clk) #1;
      bit_addr = a;
      bit_rd = 1'b1;
      @(posedge sys_clk) #1;
      bit_rd = 1'b0;
      chk(bit_rdata, e);
    end
  endtask
  // route one setting, check driven pins, then clear it
  task route(input [7:0] a, input [7:0] v, input [7:0] e);
    begin
      wr(a, v);
      chk(pin_oe, {8'h00, e});
      wr(a, (a == 8'he3) ? 8'h40 : 8'h00);
    end
  endtask
  task report_and_stop;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // main sequence
  initial
  begin
    repeat (16) @(posedge sys_clk);
    #1 rstn = 1'b1;
    rd(8'ha4, 8'h00);
    rd(8'ha5, 8'h00);
    rd(8'had, 8'hff);
    for (i = 0; i < 4; i = i + 1) rd(8'he1 + i[7:0], 8'h00);
    rd(8'h80, 8'hff);
    chk(pin_oe, 16'h0000);
    chk(pullup_en, 16'hffff);
    wr(8'he3, 8'hff);
    rd(8'he3, 8'hdc);
    chk(pullup_en, 16'h0000);
    wr(8'he3, 8'h40);
    wr(8'he5, 8'hff);
    rd(8'he5, 8'h00);
    sfr_page = 8'h00;
    rd(8'he3, 8'h00);
    wr(8'h80, 8'h00);
    rd(8'h80, 8'h00);
    chk(pin_oe, 16'h00ff);
    chk(pullup_en, 16'hff00);
    sfr_page = 8'h0f;
    wr(8'h80, 8'hff);
    route(8'he1, 8'h80, 8'h01);
    route(8'he1, 8'h40, 8'h01);
    route(8'he1, 8'h04, 8'h03);
    route(8'he1, 8'h01, 8'h03);
    for (i = 0; i < 8; i = i + 1) route(8'he2, 8'h01 << i, 8'h01);
    route(8'he3, 8'h50, 8'h01);
    route(8'he3, 8'h48, 8'h01);
    route(8'he3, 8'h44, 8'h03);
    for (i = 0; i < 4; i = i + 1) route(8'he4, 8'h01 << i, 8'h01);
    for (i = 0; i < 7; i = i + 1) route(8'he1, {2'b00, i[2:0], 3'b000}, (8'h01 << i) - 8'h01);
    route(8'he1, 8'h02, 8'h07);
    spi_four_wire = 1'b1;
    route(8'he1, 8'h02, 8'h0f);
    spi_four_wire = 1'b0;
    wr(8'ha4, 8'hff);
    periph_out = 32'hffffffff;
    route(8'he1, 8'h01, 8'hfc);
    uart0_mode0 = 1'b1;
    uart1_mode0 = 1'b1;
    route(8'he1, 8'h04, 8'hfd);
    route(8'he3, 8'h44, 8'hfd);
    uart0_mode0 = 1'b0;
    uart1_mode0 = 1'b0;
    periph_out = 32'h0;
    wr(8'ha4, 8'h00);
    wr(8'had, 8'hfe);
    wr(8'he1, 8'h37);
    chk(pin_oe, 16'h3eff);
    chk(pullup_en, 16'hc000);
    rd(8'h90, 8'hc0);
    chk(slow_adc_analog_in, 16'h0001);
    chk(periph_in[15:0], 16'h0320);
    chk(periph_in[31:16], 16'hffff);
    wr(8'he1, 8'h00);
    wr(8'h90, 8'hfe);
    chk(pin_oe, 16'h0100);
    wr(8'h90, 8'hff);
    wr(8'had, 8'hff);
    ext_low = 16'h000f;
    rd(8'h80, 8'hf0);
    rmw_read = 1'b1;
    rd(8'h80, 8'hff);
    ext_low = 16'h0000;
    @(posedge sys_clk) #1;
    bit_addr = 8'h83;
    bit_wr = 1'b1;
    @(posedge sys_clk) #1;
    bit_wr = 1'b0;
    rd(8'h80, 8'hf7);
    rmw_read = 1'b0;
    chk(pin_oe, 16'h0008);
    btrd(8'h83, 1'b0);
    btrd(8'h87, 1'b1);
    btrd(8'h94, 1'b1);
    wr(8'he4, 8'hf0);
    rd(8'he4, 8'h80);
    chk(can_tx_drive_mode, 16'h0001);
    wr(8'he3, 8'h00);
    chk(pin_oe, 16'h0000);
    report_and_stop;
  end
endmodule
`default_nettype wire
